//--- logic/iad_top.sv
// Contract
// RULE1 - enable bits 28..24 make the last datum to endpoint 5..1 of channel 1 a byte write.
// RULE2 - only the final datum of the final packet is narrowed to 8 bits, others keep width.
// RULE3 - narrowing acts only for IN transfers in automatic data count mode.
// RULE4 - software sets an enable bit only for odd-length transfers.
// RULE5 - reserved bits 31:29 and 23:0 of the conversion register read zero.
// RULE6 - peripheral requests are levels that stay until the peripheral flag clears.
// RULE7 - requests sharing a vector are ORed into 48 core interrupt lines.
// RULE8 - the core non-maskable input is the OR of the pin request and the watchdog.
// RULE9 - after reset the shared pin is a port and its non-maskable request is masked.
// RULE10 - a monitor register shows each contributing request of a line as its own bit.
// RULE11 - reading a monitor register clears no request.
// RULE12 - a selector routes each selectable request to the core or to the DMA.
// RULE13 - a channel-1 request routed to the DMA reads as zero in its monitor.
// RULE14 - software clears the peripheral request before clearing the core pending state.
// RULE15 - each line carries a 4-bit priority, sixteen levels.
// RULE16 - relocate mode 1 uses the alternate vector assignment, 0 the default one.
// RULE17 - monitors show the live request level and unused bits read zero.
module iad_top
    import iad_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire iad_bus_req_t bus_req_i,
    output logic [31:0] bus_rdata_o,
    input wire logic [47:0][7:0] src_req_i,
    input wire logic wdg_req_i,
    input wire logic nonmaskable_request_pin_n_i,
    input wire iad_dma_wr_t dma_wr_i,
    output logic [47:0] core_irq_o,
    output logic [47:0][3:0] core_prio_o,
    output logic core_nmi_o,
    output logic [4:0] dma_req_o,
    output logic [5:0] dma_width_o,
    output logic irq_o
);

    // ********************************
    // registers and state
    // ********************************
    logic [4:0] usb1_odd_packet_byte_convert_r;
    logic [4:0] dma_request_select_r;
    logic [1:0] ctrl_r;
    logic [2:0] ev_status_r;
    logic [2:0] ev_mask_r;
    logic [47:0][3:0] prio_r;
    logic pin_meta_r;
    logic pin_sync_r;
    logic [4:0] dma_req_r;
    logic [5:0] dma_width_r;
    logic core_nmi_r;
    logic [47:0] core_irq_r;
    logic [31:0] rdata_r;
    logic irq_r;

    logic [47:0][7:0] grp_gated;
    logic [47:0][7:0] line_src;
    logic [47:0] line_or;
    logic nmi_nxt;
    logic conv_hit;
    logic [5:0] width_nxt;
    logic [2:0] ev_set;
    logic [31:0] rdata_nxt;
    logic wr_convert;
    logic wr_dma_sel;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign wr_convert = bus_req_i.we && (bus_req_i.addr == OFS_CONVERT);
    assign wr_dma_sel = bus_req_i.we && (bus_req_i.addr == OFS_DMA_SEL);
    assign wr_ctrl = bus_req_i.we && (bus_req_i.addr == OFS_CTRL);
    assign wr_status = bus_req_i.we && (bus_req_i.addr == OFS_STATUS);
    assign wr_mask = bus_req_i.we && (bus_req_i.addr == OFS_MASK);

    // ********************************
    // software registers
    // ********************************
    // reserved bits are simply never stored
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            usb1_odd_packet_byte_convert_r <= CONV_RESET;
            dma_request_select_r <= DMA_SEL_RESET;
            ctrl_r <= CTRL_RESET;
            ev_mask_r <= EV_RESET;
        end
        else
        begin
            if (wr_convert)
                usb1_odd_packet_byte_convert_r <= bus_req_i.wdata[CONV_MSB:CONV_LSB]; // [RULE5]
            if (wr_dma_sel)
                dma_request_select_r <= bus_req_i.wdata[4:0];
            if (wr_ctrl)
                ctrl_r <= bus_req_i.wdata[1:0]; // [RULE9] [RULE16]
            if (wr_mask)
                ev_mask_r <= bus_req_i.wdata[EV_BITS-1:0];
        end
    end

    // priority words, eight lines of four bits per word
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < 48; i++)
                prio_r[i] <= PRIO_RESET;
        end
        else if (bus_req_i.we && bus_req_i.addr >= OFS_PRIO_BASE
                 && bus_req_i.addr <= OFS_PRIO_LAST && bus_req_i.addr[1:0] == 2'h0)
        begin
            for (int j = 0; j < 8; j++)
                prio_r[8 * ((bus_req_i.addr - OFS_PRIO_BASE) >> 2) + j]
                    <= bus_req_i.wdata[4*j +: 4]; // [RULE15]
        end
    end

    // ********************************
    // aggregation and routing
    // ********************************
    // requests are taken as live levels, nothing is latched here
    always_comb
    begin
        grp_gated = src_req_i; // [RULE6]
        for (int k = 0; k < 48; k++)
            grp_gated[k] = grp_gated[k] & ((k == USB1_GROUP) ? USB1_USED : ALL_USED); // [RULE17]
        // a request lent to the DMA leaves the core path and the monitor
        grp_gated[USB1_GROUP][4:0] = src_req_i[USB1_GROUP][4:0]
                                     & ~dma_request_select_r; // [RULE12] [RULE13]
        for (int k = 0; k < 48; k++)
        begin
            if (ctrl_r[CTRL_RELOC_BIT] && k >= RELOC_LO && k <= RELOC_HI)
                line_src[k] = grp_gated[k ^ 1]; // [RULE16]
            else
                line_src[k] = grp_gated[k];
            line_or[k] = |line_src[k]; // [RULE7]
        end
    end

    // pin passes two flops; port mode masks it until enabled
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= ~nonmaskable_request_pin_n_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign nmi_nxt = wdg_req_i | (pin_sync_r & ctrl_r[CTRL_NMI_EN_BIT]); // [RULE8] [RULE9]

    // core and DMA request outputs, one register stage
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            core_irq_r <= '0;
            core_nmi_r <= 1'b0;
            dma_req_r <= '0;
        end
        else
        begin
            core_irq_r <= line_or;
            core_nmi_r <= nmi_nxt;
            dma_req_r <= src_req_i[USB1_GROUP][4:0] & dma_request_select_r; // [RULE12]
        end
    end

    // ********************************
    // odd packet byte narrowing
    // ********************************
    // software keeps the bit clear for even lengths, no length check here [RULE4]
    always_comb
    begin
        conv_hit = 1'b0;
        if (dma_wr_i.valid && dma_wr_i.dir_in && dma_wr_i.auto_mode // [RULE3]
            && dma_wr_i.last_datum && dma_wr_i.endpoint >= 3'h1 && dma_wr_i.endpoint <= 3'h5)
            conv_hit = usb1_odd_packet_byte_convert_r[dma_wr_i.endpoint - 3'h1]; // [RULE1]
        width_nxt = conv_hit ? BYTE_WIDTH : dma_wr_i.prog_width; // [RULE2]
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            dma_width_r <= '0;
        else
            dma_width_r <= width_nxt;
    end

    // ********************************
    // event status and interrupt
    // ********************************
    assign ev_set[EV_NMI_BIT] = nmi_nxt & ~core_nmi_r;
    assign ev_set[EV_DMA_BIT] = |((src_req_i[USB1_GROUP][4:0] & dma_request_select_r) & ~dma_req_r);
    assign ev_set[EV_CONV_BIT] = conv_hit;

    // a set in the clearing cycle survives the clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ev_status_r <= EV_RESET;
        else if (wr_status)
            ev_status_r <= (ev_status_r & ~bus_req_i.wdata[EV_BITS-1:0]) | ev_set;
        else
            ev_status_r <= ev_status_r | ev_set;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_r <= 1'b0;
        else
            irq_r <= |((ev_status_r | ev_set) & ev_mask_r);
    end

    // ********************************
    // read path
    // ********************************
    // reads have no side effect on any request
    always_comb
    begin
        rdata_nxt = '0;
        if (bus_req_i.re)
        begin
            if (bus_req_i.addr == OFS_CONVERT)
                rdata_nxt[CONV_MSB:CONV_LSB] = usb1_odd_packet_byte_convert_r; // [RULE5]
            else if (bus_req_i.addr == OFS_DMA_SEL)
                rdata_nxt[4:0] = dma_request_select_r;
            else if (bus_req_i.addr == OFS_CTRL)
                rdata_nxt[1:0] = ctrl_r;
            else if (bus_req_i.addr == OFS_STATUS)
                rdata_nxt[EV_BITS-1:0] = ev_status_r;
            else if (bus_req_i.addr == OFS_MASK)
                rdata_nxt[EV_BITS-1:0] = ev_mask_r;
            else if (bus_req_i.addr == OFS_NMI_MON)
                rdata_nxt[2:0] = {wdg_req_i, pin_sync_r, nmi_nxt};
            else if (bus_req_i.addr >= OFS_PRIO_BASE && bus_req_i.addr <= OFS_PRIO_LAST
                     && bus_req_i.addr[1:0] == 2'h0)
                rdata_nxt = prio_r[8 * ((bus_req_i.addr - OFS_PRIO_BASE) >> 2) +: 8];
            else if (bus_req_i.addr >= OFS_MON_BASE && bus_req_i.addr <= OFS_MON_LAST
                     && bus_req_i.addr[1:0] == 2'h0)
                rdata_nxt[7:0] = line_src[(bus_req_i.addr - OFS_MON_BASE) >> 2]; // [RULE10] [RULE11]
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign bus_rdata_o = rdata_r;
    assign core_irq_o = core_irq_r;
    assign core_prio_o = prio_r;
    assign core_nmi_o = core_nmi_r;
    assign dma_req_o = dma_req_r;
    assign dma_width_o = dma_width_r;
    assign irq_o = irq_r;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    logic [7:0] mon0_exp;
    assign mon0_exp = src_req_i[0];

    property p_conv_ep1;
        dma_wr_i.valid && dma_wr_i.dir_in && dma_wr_i.auto_mode && dma_wr_i.last_datum
        && dma_wr_i.endpoint == 3'h1 && usb1_odd_packet_byte_convert_r[0]
        |=> dma_width_o == 6'h08;
    endproperty
    a_conv_ep1: assert property (p_conv_ep1) else $error("last datum not narrowed"); // [RULE1]

    property p_keep_width;
        !dma_wr_i.last_datum |=> dma_width_o == $past(dma_wr_i.prog_width);
    endproperty
    a_keep_width: assert property (p_keep_width) else $error("early datum width changed"); // [RULE2]

    property p_out_dir;
        !dma_wr_i.dir_in || !dma_wr_i.auto_mode |=> dma_width_o == $past(dma_wr_i.prog_width);
    endproperty
    a_out_dir: assert property (p_out_dir) else $error("narrowing outside IN auto mode"); // [RULE3]

    property p_conv_reserved;
        bus_req_i.re && bus_req_i.addr == OFS_CONVERT
        |=> bus_rdata_o[31:29] == 3'h0 && bus_rdata_o[23:0] == 24'h0;
    endproperty
    a_conv_reserved: assert property (p_conv_reserved) else $error("reserved bits set"); // [RULE5]

    property p_line_or;
        !ctrl_r[CTRL_RELOC_BIT] ##1 1'b1 |-> core_irq_o[0] == $past(|src_req_i[0]);
    endproperty
    a_line_or: assert property (p_line_or) else $error("line 0 not OR of sources"); // [RULE7]

    property p_nmi_or;
        core_nmi_o == ($past(wdg_req_i) || ($past(pin_sync_r) && $past(ctrl_r[CTRL_NMI_EN_BIT])));
    endproperty
    a_nmi_or: assert property (p_nmi_or) else $error("nmi not OR of pin and watchdog"); // [RULE8]

    property p_pin_masked;
        core_nmi_o && !$past(wdg_req_i) |-> $past(ctrl_r[CTRL_NMI_EN_BIT]);
    endproperty
    a_pin_masked: assert property (p_pin_masked) else $error("nmi from masked pin"); // [RULE9]

    property p_mon_line0;
        bus_req_i.re && bus_req_i.addr == OFS_MON_BASE
        |=> bus_rdata_o == {24'h0, $past(mon0_exp)};
    endproperty
    a_mon_line0: assert property (p_mon_line0) else $error("monitor 0 wrong"); // [RULE10]

    property p_dma_hides;
        bus_req_i.re && bus_req_i.addr == OFS_MON_BASE + 12'h090 && dma_request_select_r[0]
        && !ctrl_r[CTRL_RELOC_BIT] |=> bus_rdata_o[0] == 1'b0;
    endproperty
    a_dma_hides: assert property (p_dma_hides) else $error("lent request visible"); // [RULE13]

    property p_dma_route;
        dma_req_o[0] == $past(src_req_i[USB1_GROUP][0] & dma_request_select_r[0]);
    endproperty
    a_dma_route: assert property (p_dma_route) else $error("dma request misrouted"); // [RULE12]

endmodule : iad_top

//--- include/iad_pkg.sv
package iad_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int unsigned LINES = 48;
    localparam int unsigned SRC_PER_LINE = 8;
    localparam int unsigned USB_EPS = 5;
    localparam int unsigned PRIO_BITS = 4;
    localparam int unsigned ADDR_W = 12;
    localparam logic [5:0] BYTE_WIDTH = 6'h08;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [11:0] OFS_CONVERT = 12'h000;
    localparam logic [11:0] OFS_DMA_SEL = 12'h004;
    localparam logic [11:0] OFS_CTRL = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_MASK = 12'h010;
    localparam logic [11:0] OFS_NMI_MON = 12'h014;
    localparam logic [11:0] OFS_PRIO_BASE = 12'h020;
    localparam logic [11:0] OFS_PRIO_LAST = 12'h034;
    localparam logic [11:0] OFS_MON_BASE = 12'h100;
    localparam logic [11:0] OFS_MON_LAST = 12'h1BC;

    // ********************************
    // fields and reset values
    // ********************************
    localparam int unsigned CONV_LSB = 24;
    localparam int unsigned CONV_MSB = 28;
    localparam int unsigned CTRL_RELOC_BIT = 0;
    localparam int unsigned CTRL_NMI_EN_BIT = 1;
    localparam int unsigned EV_NMI_BIT = 0;
    localparam int unsigned EV_DMA_BIT = 1;
    localparam int unsigned EV_CONV_BIT = 2;
    localparam int unsigned EV_BITS = 3;
    localparam logic [4:0] CONV_RESET = 5'h00;
    localparam logic [4:0] DMA_SEL_RESET = 5'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [3:0] PRIO_RESET = 4'h0;

    // group that carries the channel-1 endpoint requests
    localparam int unsigned USB1_GROUP = 36;
    localparam logic [7:0] USB1_USED = 8'h1F;
    localparam logic [7:0] ALL_USED = 8'hFF;
    // lines whose groups trade places in relocate mode
    localparam int unsigned RELOC_LO = 34;
    localparam int unsigned RELOC_HI = 37;

    typedef struct packed {
        logic we;
        logic re;
        logic [11:0] addr;
        logic [31:0] wdata;
    } iad_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] endpoint;
        logic last_datum;
        logic dir_in;
        logic auto_mode;
        logic [5:0] prog_width;
    } iad_dma_wr_t;

endpackage : iad_pkg

//--- tb/iad_dma_model.sv
module iad_dma_model
    import iad_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [2:0] endpoint_i,
    input wire logic dir_in_i,
    input wire logic auto_mode_i,
    input wire logic [3:0] len_i,
    output iad_dma_wr_t dma_wr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // dma controller side: one datum per cycle
    // ****************************************
    logic [3:0] left_r;

    // idle endpoint and width keep moving so nobody can lean on stale values
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            dma_wr_o <= '0;
            left_r <= 4'h0;
        end
        else if (start_i && left_r == 4'h0)
        begin
            left_r <= len_i - 4'h1;
            dma_wr_o <= '{1'b1, endpoint_i, (len_i == 4'h1), dir_in_i, auto_mode_i, 6'h20};
        end
        else if (left_r != 4'h0)
        begin
            left_r <= left_r - 4'h1;
            dma_wr_o.last_datum <= (left_r == 4'h1);
        end
        else
        begin
            dma_wr_o.valid <= 1'b0;
            dma_wr_o.endpoint <= ~dma_wr_o.endpoint;
            dma_wr_o.prog_width <= ~dma_wr_o.prog_width;
        end
    end
endmodule : iad_dma_model

//--- tb/tb.sv
module tb;
    import iad_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus and harness
    // ****************************************
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    iad_bus_req_t bus = '0;
    logic [47:0][7:0] src = '0;
    logic wdg = 1'b0;
    logic pin_n = 1'b1;
    logic start = 1'b0;
    logic [2:0] d_ep = 3'h0;
    logic d_in = 1'b0;
    logic d_am = 1'b0;
    logic [4:0] conv_en = 5'h00;
    logic [5:0] w_exp;
    iad_dma_wr_t dma_wr;
    logic [31:0] rdata;
    logic [47:0] core_irq;
    logic [47:0][3:0] prio;
    logic nmi;
    logic [4:0] dma_req;
    logic [5:0] dma_width;
    logic irq;
    int failures = 0;
    int n_checks = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    iad_top uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_req_i(bus),
        .bus_rdata_o(rdata), .src_req_i(src), .wdg_req_i(wdg),
        .nonmaskable_request_pin_n_i(pin_n), .dma_wr_i(dma_wr), .core_irq_o(core_irq),
        .core_prio_o(prio), .core_nmi_o(nmi), .dma_req_o(dma_req),
        .dma_width_o(dma_width), .irq_o(irq));

    // odd burst length only, as narrowing demands
    iad_dma_model dma (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start),
        .endpoint_i(d_ep), .dir_in_i(d_in), .auto_mode_i(d_am), .len_i(4'h3),
        .dma_wr_o(dma_wr));

    task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_checks++;
        if (e !== g)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        bus <= '0;
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk_sys_i);
        bus <= '0;
        #1;
        chk($sformatf("reg %h", a), 48'(e), 48'(rdata));
    endtask : rd

    task dma_run(input logic [2:0] ep, input logic din, input logic am);
        @(posedge clk_sys_i);
        start <= 1'b1;
        d_ep <= ep;
        d_in <= din;
        d_am <= am;
        @(posedge clk_sys_i);
        start <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
    endtask : dma_run

    task end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    // width seen one cycle after each datum; reference built from the enable bits
    always @(posedge clk_sys_i)
    begin
        if (reset_n_i === 1'b1 && dma_wr.valid === 1'b1)
        begin
            w_exp = dma_wr.prog_width;
            if (dma_wr.last_datum && dma_wr.dir_in && dma_wr.auto_mode
                && dma_wr.endpoint inside {[3'h1:3'h5]} && conv_en[dma_wr.endpoint - 3'h1])
                w_exp = 6'h08;
            #1 chk("dma_width", 48'(w_exp), 48'(dma_width));
        end
    end

    // hang guard sized well past the whole sequence
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        failures++;
        end_of_test();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a <= 16; a += 4)
            rd(12'(a), 32'h0000_0000);
        rd(12'h0FC, 32'h0000_0000);
        wr(OFS_CONVERT, 32'hFFFF_FFFF);
        rd(OFS_CONVERT, 32'h1F00_0000);
        $display("test registers done");
        // lines that are multiples of seven, skipping 36, pattern held across two reads
        for (int k = 0; k < 48; k++)
        begin
            if (k == 36 || k == 37 || k % 7 != 0)
                continue;
            @(posedge clk_sys_i);
            src[k] <= 8'(k + 1);
            step(1);
            chk("core_irq", 48'h1 << k, core_irq);
            rd(OFS_MON_BASE + 12'(4 * k), 32'(k + 1));
            rd(OFS_MON_BASE + 12'(4 * k), 32'(k + 1));
            @(posedge clk_sys_i);
            src[k] <= 8'h00;
        end
        step(1);
        chk("core_irq", 48'h0, core_irq);
        $display("test aggregate done");
        @(posedge clk_sys_i);
        wdg <= 1'b1;
        step(1);
        chk("nmi", 48'h1, 48'(nmi));
        @(posedge clk_sys_i);
        wdg <= 1'b0;
        pin_n <= 1'b0;
        wr(OFS_STATUS, 32'h0000_0007);
        step(5);
        chk("nmi", 48'h0, 48'(nmi));
        wr(OFS_CTRL, 32'h0000_0002);
        step(4);
        chk("nmi", 48'h1, 48'(nmi));
        rd(OFS_STATUS, 32'h0000_0001);
        wr(OFS_MASK, 32'h0000_0001);
        step(1);
        chk("irq", 48'h1, 48'(irq));
        @(posedge clk_sys_i);
        pin_n <= 1'b1;
        wr(OFS_STATUS, 32'h0000_0001);
        step(2);
        chk("irq", 48'h0, 48'(irq));
        $display("test nmi done");
        wr(OFS_PRIO_BASE, 32'h0000_00F5);
        wr(OFS_PRIO_LAST, 32'h7000_0000);
        step(1);
        chk("prio", 48'h7F5, 48'({prio[47], prio[1], prio[0]}));
        rd(OFS_PRIO_BASE, 32'h0000_00F5);
        $display("test priority done");
        @(posedge clk_sys_i);
        src[36] <= 8'hFF;
        rd(OFS_MON_BASE + 12'h090, 32'h0000_001F);
        wr(OFS_DMA_SEL, 32'h0000_0003);
        step(1);
        chk("dma_req", 48'h03, 48'(dma_req));
        rd(OFS_MON_BASE + 12'h090, 32'h0000_001C);
        @(posedge clk_sys_i);
        src[36] <= 8'h03;
        step(1);
        chk("core_irq", 48'h0, core_irq);
        rd(OFS_MON_BASE + 12'h090, 32'h0000_0000);
        $display("test dma select done");
        wr(OFS_CONVERT, 32'h1500_0000);
        conv_en = 5'h15;
        for (int e = 0; e < 7; e++)
            dma_run(3'(e), 1'b1, 1'b1);
        dma_run(3'h1, 1'b0, 1'b1);
        dma_run(3'h1, 1'b1, 1'b0);
        rd(OFS_STATUS, 32'h0000_0006);
        $display("test narrowing done");
        @(posedge clk_sys_i);
        src[36] <= 8'h00;
        src[35] <= 8'h01;
        wr(OFS_CTRL, 32'h0000_0001);
        step(1);
        chk("core_irq", 48'h1 << 34, core_irq);
        rd(OFS_MON_BASE + 12'h088, 32'h0000_0001);
        $display("test relocate done");
        end_of_test();
    end
endmodule : tb
